/* sce_compare.sv */
// Purpose: sequencer for pin by pin signature comparison
// Assumes: scanner presents digitized samples per pin and range on request
// Notes: results list kept sorted by descending area via insertion
module sce_compare
    import sce_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Front panel settings
    input wire logic i_tol_set,
    input wire logic [6:0] i_tol_val,
    input wire logic i_mode_tgl,
    input wire logic i_order_tgl,
    input wire logic i_cyc_set,
    input wire logic [6:0] i_cyc_val,
    input wire logic [SCE_RANGES-1:0] i_rng_tgl,
    input wire logic i_store,
    input wire logic [SCE_PIN_W-1:0] i_pin_last,
    // Front panel commands
    input wire logic i_start,
    input wire logic i_continue,
    input wire logic i_abort,
    input wire logic [SCE_PIN_W-1:0] i_res_idx,
    // Scanner sample stream
    input wire logic i_smp_valid,
    input wire logic [SCE_SAMP_W-1:0] i_smp_ref,
    input wire logic [SCE_SAMP_W-1:0] i_smp_sus,
    // Scanner request
    output logic o_scan_req,
    output logic [SCE_PIN_W-1:0] o_scan_pin,
    output logic [SCE_RNG_W-1:0] o_scan_rng,
    // Settings and status
    output sce_cfg_s o_cfg,
    output sce_cfg_s o_cfg_default,
    output logic [SCE_RANGES-1:0] o_rng_en,
    output logic o_busy,
    output logic o_halted,
    output logic o_pass,
    output logic o_fail,
    output sce_result_s o_halt_info,
    output logic [SCE_PIN_W:0] o_fail_count,
    output sce_result_s o_res_entry
);
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_REQ = 6'b000010,
        ST_SAMP = 6'b000100,
        ST_EVAL = 6'b001000,
        ST_HALT = 6'b010000,
        ST_STEP = 6'b100000
    } sce_state_e;

    sce_state_e state_ff, nxt_state;
    sce_cfg_s cfg_ff, dflt_ff;
    logic [SCE_RANGES-1:0] rng_en_ff;
    logic [SCE_PIN_W-1:0] pin_ff;
    logic [SCE_RNG_W-1:0] rng_ff;
    logic [6:0] smp_ff;
    logic [6:0] cyc_ff;
    logic fail_ff, pass_ff, halted_before_ff;
    sce_result_s halt_ff;
    sce_result_s list_ff [SCE_MAX_FAIL];
    logic [SCE_PIN_W:0] cnt_ff;
    logic pd_mis;
    logic [7:0] pd_dev;
    logic [SCE_AREA_W-1:0] pd_area;

    // Store copies live settings; defaults reload on power-up only
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            dflt_ff <= '{tol: SCE_TOL_RST, stop_mode: 1'b0, pin_major: 1'b0,
                         cycles: SCE_CYC_RST};
        end
        else if (i_store)
        begin
            dflt_ff <= cfg_ff;
        end
    end

    // Settings frozen while a comparison runs
    wire idle = state_ff == ST_IDLE;
    wire tol_ok = i_tol_val <= SCE_TOL_MAX;
    wire cyc_ok = i_cyc_val <= SCE_CYC_MAX;
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            cfg_ff <= '{tol: SCE_TOL_RST, stop_mode: 1'b0, pin_major: 1'b0,
                        cycles: SCE_CYC_RST};
            rng_en_ff <= '1;
        end
        else if (idle)
        begin
            if (i_tol_set && tol_ok)
                cfg_ff.tol <= i_tol_val;
            if (i_mode_tgl)
                cfg_ff.stop_mode <= ~cfg_ff.stop_mode;
            if (i_order_tgl)
                cfg_ff.pin_major <= ~cfg_ff.pin_major;
            if (i_cyc_set && cyc_ok)
                cfg_ff.cycles <= i_cyc_val;
            rng_en_ff <= rng_en_ff ^ i_rng_tgl;
        end
    end

    // Next enabled range, wrapping, from the current one
    logic [SCE_RNG_W-1:0] next_rng;
    logic next_rng_wrap;
    logic [SCE_RNG_W-1:0] first_rng;
    always_comb
    begin
        next_rng = rng_ff;
        next_rng_wrap = 1'b1;
        first_rng = '0;
        for (int i = SCE_RANGES - 1; i >= 0; i--)
        begin
            if (rng_en_ff[i])
                first_rng = SCE_RNG_W'(i);
        end
        for (int i = SCE_RANGES - 1; i >= 0; i--)
        begin
            if (rng_en_ff[i] && SCE_RNG_W'(i) > rng_ff && i > int'(rng_ff))
            begin
                next_rng = SCE_RNG_W'(i);
                next_rng_wrap = 1'b0;
            end
        end
        if (next_rng_wrap)
            next_rng = first_rng;
    end

    wire pin_end = pin_ff == i_pin_last;
    wire any_rng = |rng_en_ff;
    // Order decides which index is the inner loop
    wire inner_end = cfg_ff.pin_major ? pin_end : next_rng_wrap;
    wire outer_end = cfg_ff.pin_major ? next_rng_wrap : pin_end;
    wire pass_end = inner_end && outer_end;
    wire endless = cfg_ff.cycles == SCE_CYC_ENDLESS;
    wire last_cycle = !endless && (cyc_ff == cfg_ff.cycles);
    wire smp_last = smp_ff == SCE_SAMP_LAST;
    wire smp_take = (state_ff == ST_SAMP) && i_smp_valid;

    sce_pin_diff u_diff (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_valid(smp_take),
        .i_first(smp_ff == 7'h00),
        .i_ref(i_smp_ref),
        .i_sus(i_smp_sus),
        .i_tol(cfg_ff.tol),
        .o_mismatch(pd_mis),
        .o_dev(pd_dev),
        .o_area(pd_area)
    );

    wire halt_now = pd_mis && cfg_ff.stop_mode && !halted_before_ff;
    // Endless mode ends on the pass that found a mismatch
    wire fail_seen = fail_ff || pd_mis;
    wire done_now = pass_end && (last_cycle || (endless && fail_seen));

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
                if (i_start && any_rng)
                    nxt_state = ST_REQ;
            ST_REQ:
                nxt_state = ST_SAMP;
            ST_SAMP:
                if (smp_take && smp_last)
                    nxt_state = ST_EVAL;
            ST_EVAL:
                if (halt_now)
                    nxt_state = ST_HALT;
                else if (done_now)
                    nxt_state = ST_IDLE;
                else
                    nxt_state = ST_STEP;
            ST_HALT:
                if (i_continue)
                    nxt_state = done_now ? ST_IDLE : ST_STEP;
            ST_STEP:
                nxt_state = ST_REQ;
            default:
                nxt_state = ST_IDLE;
        endcase
        if (i_abort && state_ff != ST_IDLE)
            nxt_state = ST_IDLE;
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            state_ff <= ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    // Sample index within the current pin
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            smp_ff <= 7'h00;
        else if (state_ff == ST_REQ)
            smp_ff <= 7'h00;
        else if (smp_take)
            smp_ff <= smp_last ? 7'h00 : smp_ff + 7'h01;
    end

    // Pin, range and cycle stepping
    wire stepping = (state_ff == ST_STEP);
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            pin_ff <= '0;
            rng_ff <= '0;
            cyc_ff <= 7'h01;
        end
        else if (idle && i_start)
        begin
            pin_ff <= '0;
            rng_ff <= first_rng;
            cyc_ff <= 7'h01;
        end
        else if (stepping)
        begin
            if (cfg_ff.pin_major)
            begin
                pin_ff <= pin_end ? '0 : pin_ff + 6'h01;
                if (pin_end)
                    rng_ff <= next_rng;
            end
            else
            begin
                rng_ff <= next_rng;
                if (next_rng_wrap)
                    pin_ff <= pin_end ? '0 : pin_ff + 6'h01;
            end
            if (pass_end && !endless)
                cyc_ff <= cyc_ff + 7'h01;
        end
    end

    // Verdict and halt capture
    wire eval = state_ff == ST_EVAL;
    wire cur_fail = eval && pd_mis;
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            fail_ff <= 1'b0;
            pass_ff <= 1'b0;
            halted_before_ff <= 1'b0;
            halt_ff <= '0;
        end
        else if (idle && i_start)
        begin
            fail_ff <= 1'b0;
            pass_ff <= 1'b0;
            halted_before_ff <= 1'b0;
        end
        else if (eval)
        begin
            if (pd_mis)
                fail_ff <= 1'b1;
            if (halt_now)
            begin
                halted_before_ff <= 1'b1;
                halt_ff <= '{pin: pin_ff, rng: rng_ff, dev: pd_dev, area: pd_area};
            end
            if (done_now && !fail_seen)
                pass_ff <= 1'b1;
        end
    end

    // Insertion keeps the list descending; only the first pass, or any pass in endless mode, is recorded
    wire rec = cur_fail && (cyc_ff == 7'h01) && (cnt_ff < (SCE_PIN_W+1)'(SCE_MAX_FAIL));
    sce_result_s new_ent;
    assign new_ent = '{pin: pin_ff, rng: rng_ff, dev: pd_dev, area: pd_area};
    genvar g;
    generate
        for (g = 0; g < SCE_MAX_FAIL; g++)
        begin : g_list
            wire below = (g < int'(cnt_ff)) && (list_ff[g].area >= pd_area);
            wire prev_below;
            if (g == 0)
                assign prev_below = 1'b1;
            else
                assign prev_below = (g - 1 < int'(cnt_ff)) && (list_ff[g-1].area >= pd_area);
            always_ff @(posedge i_clk or negedge i_nrst)
            begin
                if (!i_nrst)
                    list_ff[g] <= '0;
                else if (rec && !below)
                begin
                    if (prev_below)
                        list_ff[g] <= new_ent;
                    else
                        list_ff[g] <= list_ff[(g == 0) ? 0 : g - 1];
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            cnt_ff <= '0;
        else if (idle && i_start)
            cnt_ff <= '0;
        else if (rec)
            cnt_ff <= cnt_ff + 7'h01;
    end

    assign o_scan_req = (state_ff == ST_REQ) || (state_ff == ST_SAMP);
    assign o_scan_pin = pin_ff;
    assign o_scan_rng = rng_ff;
    assign o_cfg = cfg_ff;
    assign o_cfg_default = dflt_ff;
    assign o_rng_en = rng_en_ff;
    assign o_busy = !idle;
    assign o_halted = state_ff == ST_HALT;
    assign o_pass = pass_ff;
    assign o_fail = fail_ff;
    assign o_halt_info = halt_ff;
    assign o_fail_count = cnt_ff;
    assign o_res_entry = list_ff[i_res_idx];
endmodule

/* sce_pkg.sv */
// Purpose: shared constants and carriers for the signature comparison engine
// Assumes: 8-bit samples, up to 64 pins, up to 8 ranges
// Notes: cycle value 0 selects endless repetition
package sce_pkg;
    localparam int SCE_SAMPLES = 100;
    localparam int SCE_SAMP_W = 8;
    localparam int SCE_PIN_W = 6;
    localparam int SCE_RANGES = 8;
    localparam int SCE_RNG_W = 3;
    localparam int SCE_AREA_W = 16;
    localparam int SCE_MAX_FAIL = 64;
    localparam logic [6:0] SCE_TOL_MAX = 7'h63;
    localparam logic [6:0] SCE_CYC_MAX = 7'h63;
    localparam logic [6:0] SCE_CYC_ENDLESS = 7'h00;
    localparam logic [6:0] SCE_TOL_RST = 7'h0A;
    localparam logic [6:0] SCE_CYC_RST = 7'h01;
    localparam logic [6:0] SCE_SAMP_LAST = 7'h63;

    typedef struct packed {
        logic [6:0] tol;
        logic stop_mode;
        logic pin_major;
        logic [6:0] cycles;
    } sce_cfg_s;

    typedef struct packed {
        logic [SCE_PIN_W-1:0] pin;
        logic [SCE_RNG_W-1:0] rng;
        logic [7:0] dev;
        logic [SCE_AREA_W-1:0] area;
    } sce_result_s;
endpackage

/* sce_pin_diff.sv */
// Purpose: per-pin sample difference, peak deviation and area accumulation
// Assumes: one sample pair per valid cycle, first flagged by i_first
// Notes: outputs settle the cycle after the last sample
module sce_pin_diff
    import sce_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Sample stream
    input wire logic i_valid,
    input wire logic i_first,
    input wire logic [SCE_SAMP_W-1:0] i_ref,
    input wire logic [SCE_SAMP_W-1:0] i_sus,
    input wire logic [6:0] i_tol,
    // Result
    output logic o_mismatch,
    output logic [7:0] o_dev,
    output logic [SCE_AREA_W-1:0] o_area
);
    logic [7:0] dev_ff;
    logic [SCE_AREA_W-1:0] area_ff;
    logic mis_ff;
    wire [SCE_SAMP_W-1:0] mag = (i_sus >= i_ref) ? i_sus - i_ref : i_ref - i_sus;
    wire [7:0] tol8 = {1'b0, i_tol};
    // Tolerance is an offset, not a scale
    wire over = mag > tol8;
    wire [7:0] excess = over ? mag - tol8 : 8'h00;
    wire [7:0] base_dev = i_first ? 8'h00 : dev_ff;
    wire [SCE_AREA_W-1:0] base_area = i_first ? '0 : area_ff;
    wire [7:0] nxt_dev = (excess > base_dev) ? excess : base_dev;
    wire [SCE_AREA_W-1:0] nxt_area = base_area + {8'h00, excess};
    wire nxt_mis = (i_first ? 1'b0 : mis_ff) | over;

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            dev_ff <= 8'h00;
            area_ff <= '0;
            mis_ff <= 1'b0;
        end
        else if (i_valid)
        begin
            dev_ff <= nxt_dev;
            area_ff <= nxt_area;
            mis_ff <= nxt_mis;
        end
    end

    assign o_dev = dev_ff;
    assign o_area = area_ff;
    assign o_mismatch = mis_ff;
endmodule

/* sce_compare_assertions.sv */
// Purpose: port checks for sce_compare
// Assumes: sees only the top ports
// Notes: sample count helper clears whenever no request stands
module sce_compare_assertions
    import sce_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Inputs watched
    input wire logic i_tol_set,
    input wire logic [6:0] i_tol_val,
    input wire logic i_mode_tgl,
    input wire logic i_order_tgl,
    input wire logic [SCE_RANGES-1:0] i_rng_tgl,
    input wire logic i_store,
    input wire logic i_start,
    input wire logic i_continue,
    input wire logic i_abort,
    input wire logic [SCE_PIN_W-1:0] i_pin_last,
    input wire logic i_smp_valid,
    // Outputs watched
    input wire logic o_scan_req,
    input wire logic [SCE_PIN_W-1:0] o_scan_pin,
    input wire sce_cfg_s o_cfg,
    input wire sce_cfg_s o_cfg_default,
    input wire logic [SCE_RANGES-1:0] o_rng_en,
    input wire logic o_busy,
    input wire logic o_halted,
    input wire logic o_pass,
    input wire logic o_fail,
    input wire sce_result_s o_halt_info,
    input wire logic [SCE_PIN_W:0] o_fail_count
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    logic req_d_ff;
    logic [7:0] smp_cnt_ff;
    // First request cycle carries no sample, so counting starts one cycle late
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            req_d_ff <= 1'b0;
            smp_cnt_ff <= 8'h00;
        end
        else
        begin
            req_d_ff <= o_scan_req;
            smp_cnt_ff <= !o_scan_req ? 8'h00 : smp_cnt_ff + 8'(req_d_ff && i_smp_valid);
        end
    end
    AST_START_REQ: assert property (i_start && !o_busy && |o_rng_en |=> o_busy && o_scan_req)
        else $error("start not taken");
    AST_SAMPLES: assert property ($fell(o_scan_req) && !$past(i_abort) |-> smp_cnt_ff == 8'h64)
        else $error("pin ended without 100 samples");
    AST_TOL_LOAD: assert property (i_tol_set && !o_busy && i_tol_val <= SCE_TOL_MAX
        |=> o_cfg.tol == $past(i_tol_val))
        else $error("tolerance not loaded");
    AST_BOUNDS: assert property (o_cfg.tol <= SCE_TOL_MAX && o_cfg.cycles <= SCE_CYC_MAX)
        else $error("setting out of range");
    AST_BUSY_HOLD: assert property (o_busy |=> $stable(o_cfg) && $stable(o_rng_en))
        else $error("settings moved while busy");
    AST_MODE_TGL: assert property (i_mode_tgl && !o_busy |=> o_cfg.stop_mode != $past(o_cfg.stop_mode))
        else $error("mode not toggled");
    AST_ORDER_TGL: assert property (i_order_tgl && !o_busy |=> $changed(o_cfg.pin_major))
        else $error("order not toggled");
    AST_RNG_TGL: assert property (i_rng_tgl != 8'h00 && !o_busy
        |=> o_rng_en == ($past(o_rng_en) ^ $past(i_rng_tgl)))
        else $error("range enables wrong");
    AST_STORE: assert property (i_store |=> o_cfg_default == $past(o_cfg))
        else $error("defaults not stored");
    AST_VERDICT: assert property (o_pass |-> !o_fail && o_fail_count == 7'h00)
        else $error("pass with failures");
    AST_HALT_INFO: assert property ($rose(o_halted)
        |-> o_cfg.stop_mode && o_halt_info.dev != 8'h00 && o_halt_info.pin == o_scan_pin)
        else $error("halt info wrong");
    AST_HALT_HOLD: assert property (o_halted && !i_continue && !i_abort |=> o_halted && !o_scan_req)
        else $error("halt not held");
    AST_PIN_BOUND: assert property (o_scan_req |-> o_scan_pin <= i_pin_last)
        else $error("pin past last");
    cover property ($rose(o_halted));
    cover property ($rose(o_pass));
    cover property ($rose(o_fail) && o_fail_count > 7'h01);
endmodule

/* sce_scan_model.sv */
// Purpose: behavioural scanner feeding sample pairs
// Assumes: four pins, per-pin offset from the bench
// Notes: idle data lines show the inverse of the last value
module sce_scan_model
    import sce_pkg::*;
(
    // Clock
    input wire logic i_clk,
    // Request
    input wire logic i_req,
    input wire logic [SCE_PIN_W-1:0] i_pin,
    input wire logic [SCE_RNG_W-1:0] i_rng,
    // Bench control
    input wire logic [31:0] i_delta,
    input wire logic i_slow,
    // Samples
    output logic o_valid,
    output logic [SCE_SAMP_W-1:0] o_ref,
    output logic [SCE_SAMP_W-1:0] o_sus
);
    timeunit 1ns;
    timeprecision 1ps;
    int n = 0;
    int d;
    int r;
    logic ph = 1'b0;
    initial
    begin
        o_valid = 1'b0;
        o_ref = 8'hA5;
        o_sus = 8'h5A;
    end
    always @(posedge i_clk)
    begin
        ph <= ~ph;
        d = i_delta[i_pin[1:0]*8 +: 8] / (n < 50 ? 1 : 2);
        r = 60 + n % 40 + int'(i_rng);
        if (i_req && n < SCE_SAMPLES && !(i_slow && ph))
        begin
            o_valid <= 1'b1;
            o_ref <= 8'(r);
            o_sus <= i_pin[0] ? 8'(r - d) : 8'(r + d);
            n <= n + 1;
        end
        else
        begin
            o_valid <= 1'b0;
            o_ref <= ~o_ref;
            o_sus <= ~o_sus;
            n <= i_req ? n : 0;
        end
    end
endmodule

/* sce_compare_test.sv */
// Purpose: self-checking bench for sce_compare
// Assumes: pins 0 to 3, ranges 0 and 1 enabled
// Notes: odd pins sit below the reference, even pins above
module sce_compare_test
    import sce_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TOL = 0, CYC = 1, MODE = 2, ORD = 3, RNG = 4, STORE = 5, GO = 6, CONT = 7;
    localparam int ABORT = 8;
    logic i_clk = 1'b0, i_nrst = 1'b0, slow = 1'b0, req_d = 1'b0;
    logic i_tol_set = 1'b0, i_mode_tgl = 1'b0, i_order_tgl = 1'b0, i_cyc_set = 1'b0;
    logic i_store = 1'b0, i_start = 1'b0, i_continue = 1'b0, i_abort = 1'b0;
    logic [6:0] i_tol_val = 7'h00, i_cyc_val = 7'h00;
    logic [SCE_RANGES-1:0] i_rng_tgl = 8'h00, o_rng_en;
    logic [SCE_PIN_W-1:0] i_pin_last = 6'h03, i_res_idx = 6'h00, o_scan_pin;
    logic i_smp_valid, o_scan_req, o_busy, o_halted, o_pass, o_fail;
    logic [SCE_SAMP_W-1:0] i_smp_ref, i_smp_sus;
    logic [SCE_RNG_W-1:0] o_scan_rng;
    logic [SCE_PIN_W:0] o_fail_count;
    logic [31:0] delta = 32'h0;
    sce_cfg_s o_cfg, o_cfg_default;
    sce_result_s o_halt_info, o_res_entry;
    int bad_count = 0, cmp_count = 0;
    int visits[$], want[$];
    sce_compare dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_tol_set(i_tol_set),
        .i_tol_val(i_tol_val), .i_mode_tgl(i_mode_tgl), .i_order_tgl(i_order_tgl),
        .i_cyc_set(i_cyc_set), .i_cyc_val(i_cyc_val), .i_rng_tgl(i_rng_tgl), .i_store(i_store),
        .i_pin_last(i_pin_last), .i_start(i_start), .i_continue(i_continue), .i_abort(i_abort),
        .i_res_idx(i_res_idx), .i_smp_valid(i_smp_valid), .i_smp_ref(i_smp_ref),
        .i_smp_sus(i_smp_sus), .o_scan_req(o_scan_req), .o_scan_pin(o_scan_pin),
        .o_scan_rng(o_scan_rng), .o_cfg(o_cfg), .o_cfg_default(o_cfg_default),
        .o_rng_en(o_rng_en), .o_busy(o_busy), .o_halted(o_halted), .o_pass(o_pass),
        .o_fail(o_fail), .o_halt_info(o_halt_info), .o_fail_count(o_fail_count),
        .o_res_entry(o_res_entry));
    sce_scan_model scan_u (.i_clk(i_clk), .i_req(o_scan_req), .i_pin(o_scan_pin),
        .i_rng(o_scan_rng), .i_delta(delta), .i_slow(slow), .o_valid(i_smp_valid),
        .o_ref(i_smp_ref), .o_sus(i_smp_sus));
    initial
        forever #5 i_clk = ~i_clk;
    always @(posedge i_clk)
    begin
        req_d <= o_scan_req;
        if (o_scan_req && !req_d)
            visits.push_back(int'(o_scan_pin) * 8 + int'(o_scan_rng));
    end
    function automatic int excess(int d, int t);
        return (d > t) ? d - t : 0;
    endfunction
    function automatic int area_of(int d, int t);
        return 50 * excess(d, t) + 50 * excess(d / 2, t);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic press(input int which, input logic [7:0] val);
        @(posedge i_clk);
        {i_tol_val, i_cyc_val} <= {val[6:0], val[6:0]};
        // Bit n of the one-hot code maps to command n
        {i_order_tgl, i_mode_tgl, i_cyc_set, i_tol_set} <= 4'(1 << which);
        {i_abort, i_continue, i_start, i_store} <= 4'(1 << which >> 5);
        i_rng_tgl <= (which == RNG) ? val : 8'h00;
        @(posedge i_clk);
        {i_tol_set, i_cyc_set, i_mode_tgl, i_order_tgl, i_store, i_start, i_continue} <= 7'h00;
        {i_abort, i_rng_tgl} <= 9'h000;
        #1;
    endtask
    task automatic run(input int cmd, input int reps, input bit pm);
        int i;
        visits.delete();
        press(cmd, 8'h00);
        i = 0;
        while (o_busy && !o_halted && i < 20000)
        begin
            // Look after the edge so state outputs have settled
            @(posedge i_clk);
            #1;
            i++;
        end
        chk(i < 20000, 1'b1);
        want.delete();
        for (int a = 0; a < reps * 8; a++)
            want.push_back(pm ? a % 4 * 8 + a / 4 % 2 : a / 2 % 4 * 8 + a % 2);
        if (reps > 0)
            chk(visits.size(), want.size());
        foreach (want[k]) chk(visits[k], want[k]);
    endtask
    task automatic chk_list(input int tol);
        want.delete();
        for (int p = 0; p < 8; p++)
            if (delta[p % 4 * 8 +: 8] > tol)
                want.push_back(area_of(delta[p % 4 * 8 +: 8], tol));
        want.rsort();
        chk({o_pass, o_fail, o_fail_count}, {want.size() == 0, want.size() != 0, 7'(want.size())});
        foreach (want[k])
        begin
            @(posedge i_clk);
            i_res_idx <= 6'(k);
            @(posedge i_clk);
            #1;
            chk(o_res_entry.area, want[k]);
            chk(o_res_entry.dev, excess(delta[o_res_entry.pin * 8 +: 8], tol));
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        repeat (40000) @(posedge i_clk);
        bad_count++;
        $display("ERROR %0t: watchdog expired", $time);
        print_verdict();
    end
    initial
    begin
        int tol;
        int p0;
        void'($urandom(32'hB1BE3D33));
        repeat (4) @(posedge i_clk);
        i_nrst <= 1'b1;
        #1;
        chk({o_cfg, o_cfg_default}, {SCE_TOL_RST, 2'b00, SCE_CYC_RST, SCE_TOL_RST, 2'b00, SCE_CYC_RST});
        chk(o_rng_en, 8'hFF);
        press(RNG, 8'hFC);
        press(TOL, 8'h64);
        chk(o_cfg.tol, SCE_TOL_RST);
        press(TOL, 8'h63);
        press(CYC, 8'h02);
        press(STORE, 8'h00);
        chk({o_cfg_default, o_rng_en}, {7'h63, 2'b00, 7'h02, 8'h03});
        $display("settings test done");
        tol = 10 + $urandom % 20;
        press(TOL, 8'(tol));
        for (int p = 0; p < 4; p++)
            delta[p * 8 +: 8] <= 8'($urandom % (tol + 1));
        slow <= 1'b1;
        run(GO, 2, 1'b0);
        chk_list(tol);
        $display("two cycle pass test done");
        tol = $urandom % 16;
        press(TOL, 8'(tol));
        press(CYC, 8'h01);
        press(ORD, 8'h00);
        delta <= {8'($urandom % 61), 8'h3C, 8'($urandom % 61), 8'(tol)};
        slow <= 1'b0;
        run(GO, 1, 1'b1);
        chk_list(tol);
        $display("run to end test done");
        press(ORD, 8'h00);
        press(MODE, 8'h00);
        run(GO, 0, 1'b0);
        p0 = 9;
        for (int p = 3; p >= 0; p--)
            if (delta[p * 8 +: 8] > tol)
                p0 = p;
        chk({o_halted, o_halt_info.pin, o_halt_info.rng}, {1'b1, 6'(p0), 3'h0});
        chk(o_halt_info.dev, excess(delta[p0 * 8 +: 8], tol));
        chk(o_halt_info.area, area_of(delta[p0 * 8 +: 8], tol));
        run(CONT, 0, 1'b0);
        chk_list(tol);
        $display("halt and continue test done");
        press(MODE, 8'h00);
        press(CYC, 8'h00);
        run(GO, 1, 1'b0);
        chk_list(tol);
        delta <= 32'h0;
        slow <= 1'b1;
        press(GO, 8'h00);
        repeat (1500) @(posedge i_clk);
        press(TOL, 8'h05);
        press(ABORT, 8'h00);
        chk({o_busy, o_pass, o_cfg.tol}, {2'b00, 7'(tol)});
        $display("endless test done");
        print_verdict();
    end
endmodule
bind sce_compare sce_compare_assertions chk_u (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_tol_set(i_tol_set), .i_tol_val(i_tol_val), .i_mode_tgl(i_mode_tgl),
    .i_order_tgl(i_order_tgl), .i_rng_tgl(i_rng_tgl), .i_store(i_store), .i_start(i_start),
    .i_continue(i_continue), .i_abort(i_abort), .i_pin_last(i_pin_last),
    .i_smp_valid(i_smp_valid), .o_scan_req(o_scan_req), .o_scan_pin(o_scan_pin),
    .o_cfg(o_cfg), .o_cfg_default(o_cfg_default), .o_rng_en(o_rng_en), .o_busy(o_busy),
    .o_halted(o_halted), .o_pass(o_pass), .o_fail(o_fail), .o_halt_info(o_halt_info),
    .o_fail_count(o_fail_count));
